/* logic/adcc_pkg.sv */
package adcc_pkg;

   // register bus geometry
   localparam int         AXI_AW       = 6;
   localparam int         AXI_DW       = 32;
   localparam logic [1:0] RESP_OKAY    = 2'b00;
   localparam logic [1:0] RESP_SLVERR  = 2'b10;

   // byte offsets, one aligned word each
   localparam logic [5:0] OFF_SC1      = 6'h00;
   localparam logic [5:0] OFF_SC2      = 6'h04;
   localparam logic [5:0] OFF_RES_HI   = 6'h08;
   localparam logic [5:0] OFF_RES_LO   = 6'h0C;
   localparam logic [5:0] OFF_CV_HI    = 6'h10;
   localparam logic [5:0] OFF_CV_LO    = 6'h14;
   localparam logic [5:0] OFF_CFG      = 6'h18;
   localparam logic [5:0] OFF_PIN1     = 6'h1C;
   localparam logic [5:0] OFF_PIN2     = 6'h20;

   // converter_config fields
   localparam int CFG_LP_BIT    = 7;
   localparam int CFG_DIV_LSB   = 5;
   localparam int CFG_LSMP_BIT  = 4;
   localparam int CFG_MODE_LSB  = 2;
   localparam int CFG_ICLK_LSB  = 0;

   // status_control_two fields
   localparam int SC2_ACT_BIT   = 7;
   localparam int SC2_TRG_BIT   = 6;
   localparam int SC2_CFE_BIT   = 5;
   localparam int SC2_CFGT_BIT  = 4;

   // status_control_one fields
   localparam int SC1_CONVERSION_COMPLETE_FLAG_BIT  = 7;
   localparam int SC1_COMPLETE_IRQ_ENABLE_BIT  = 6;
   localparam int SC1_CONT_BIT  = 5;
   localparam int SC1_CH_LSB    = 0;

   // values after reset
   localparam logic [7:0] CFG_RST      = 8'h00;
   localparam logic [7:0] SC1_RST      = 8'h00;
   localparam logic [2:0] SC2_RST      = 3'h0;
   localparam logic [7:0] BYTE_RST     = 8'h00;

   // field encodings
   localparam logic [1:0] MODE_8BIT    = 2'b00;
   localparam logic [1:0] MODE_10BIT   = 2'b10;
   localparam logic [1:0] ICLK_BUS     = 2'b00;
   localparam logic [1:0] ICLK_BUS_DIV2 = 2'b01;

   // sample phase in half conversion clock periods, rounded up to whole ticks
   localparam int         SAMPLE_SHORT_HALF  = 7;
   localparam int         SAMPLE_LONG_HALF   = 47;
   localparam logic [4:0] SAMPLE_SHORT_TICKS = 5'((SAMPLE_SHORT_HALF + 1) / 2);
   localparam logic [4:0] SAMPLE_LONG_TICKS  = 5'((SAMPLE_LONG_HALF + 1) / 2);

   // bus clocks a trial code stands before the comparator is believed
   localparam logic [2:0] SETTLE_CLKS  = 3'd4;
   localparam logic [3:0] CODE_MSB     = 4'd9;
   localparam logic [3:0] STOP_10BIT   = 4'd0;
   localparam logic [3:0] STOP_8BIT    = 4'd2;

   typedef enum logic [1:0]
   {
      ST_IDLE    = 2'b00,
      ST_SAMPLE  = 2'b01,
      ST_CONVERT = 2'b11,
      ST_FINISH  = 2'b10
   } adcc_state_t;

   typedef struct packed
   {
      logic       sample;
      logic [4:0] channel;
      logic [9:0] code;
      logic       low_power;
      logic       active;
   } adcc_ana_t;

endpackage

/* logic/adcc_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_sync3 #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } adcc_sync_t;

   adcc_sync_t st_r;
   adcc_sync_t st_nxt;

   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // a bit moves only once two stages agree
      for (int i = 0; i < W; i++)
      begin
         if (st_r.s2[i] == st_r.s3[i])
         begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.q;
endmodule
`default_nettype wire

/* logic/adcc_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_tick (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] input_clock_select,
   input  wire logic [1:0] clock_divide_select,
   input  wire logic       alt_clk,
   output logic            tick
);
   import adcc_pkg::*;

   typedef struct packed
   {
      logic       half;
      logic       alt_prev;
      logic [2:0] cnt;
      logic       tick;
   } adcc_tick_t;

   adcc_tick_t st_r;
   adcc_tick_t st_nxt;
   logic       src;
   logic [2:0] div_max;

   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.half     = !st_r.half;
      st_nxt.alt_prev = alt_clk;
      st_nxt.tick     = 1'b0;
      div_max = 3'((4'h1 << clock_divide_select) - 4'h1);
      case (input_clock_select)
         ICLK_BUS:      src = 1'b1;
         ICLK_BUS_DIV2: src = st_r.half;
         default:       src = alt_clk && !st_r.alt_prev;
      endcase
      if (src)
      begin
         if (st_r.cnt >= div_max)
         begin
            st_nxt.cnt  = 3'd0;
            st_nxt.tick = 1'b1;
         end
         else
         begin
            st_nxt.cnt = 3'(st_r.cnt + 3'd1);
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;
endmodule
`default_nettype wire

/* logic/adcc_ctrl.sv */
// Summary of operation
// - top config bit selects low power
// - config bits 6:5 divide conversion clock
// - config bit 4 picks long sample
// - sample lasts 3.5 or 23.5 clocks, rounded up to 4 or 24 ticks
// - config bits 3:2 pick resolution, 10=10-bit
// - config bits 1:0 pick clock, 00=bus
// - control two: active, trigger, compare enable, direction
// - control two bits 3:0 read zero
// - control one bit 7 completion flag
// - control one bit 6 interrupt enable
// - control one bit 5 continuous mode
// - control one bits 4:0 channel select
// - result high read freezes low byte
// - compare value gates result when enabled
// - pin control bits disable digital pins
// - full scale gives all ones, floor zero
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [adcc_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [adcc_pkg::AXI_DW-1:0] s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [adcc_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [adcc_pkg::AXI_DW-1:0]   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   output adcc_pkg::adcc_ana_t           ana_o,
   input  wire logic                     ana_cmp_above,
   input  wire logic                     hw_trigger,
   input  wire logic                     alt_clk_pin,
   output logic [15:0]                   pin_digital_disable,
   output logic                          complete_irq
);
   import adcc_pkg::*;

   typedef struct packed
   {
      logic              aw_have;
      logic [AXI_AW-1:0] aw_addr;
      logic              w_have;
      logic [7:0]        w_data;
      logic              w_lane;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [AXI_DW-1:0] rdata;
      logic [1:0]        rresp;
      logic [7:0]        cfg;
      logic              trg;
      logic              cfe;
      logic              cfgt;
      logic              conversion_complete_flag;
      logic              complete_irq_enable;
      logic              cont;
      logic [4:0]        ch;
      logic [7:0]        cv_hi;
      logic [7:0]        cv_lo;
      logic [7:0]        pin1;
      logic [7:0]        pin2;
      logic [9:0]        res;
      logic              lock;
      logic [7:0]        low_hold;
      adcc_state_t       state;
      logic [4:0]        cnt;
      logic [2:0]        settle;
      logic [9:0]        code;
      logic [3:0]        pos;
      logic              trig_prev;
      logic              irq;
      adcc_ana_t         ana;
   } adcc_ctrl_t;

   adcc_ctrl_t st_r;
   adcc_ctrl_t st_nxt;

   logic [2:0]  sync_q;
   logic        cmp_q;
   logic        trig_q;
   logic        alt_q;
   logic        tick;
   logic        sc1_wr;
   logic        hw_start;
   logic        set_flag;
   logic [4:0]  samp_ticks;
   logic [3:0]  stop_pos;
   logic        mode8;
   logic [9:0]  res_new;
   logic [15:0] cv_full;
   logic        cmp_ok;

   function automatic logic [7:0] byte_wr(input logic [7:0] old_v,
                                          input logic [7:0] new_v,
                                          input logic       lane);
      byte_wr = lane ? new_v : old_v;
   endfunction

   function automatic logic [5:0] word_off(input logic [AXI_AW-1:0] a);
      word_off = {a[AXI_AW-1:2], 2'b00};
   endfunction

   adcc_sync3 #(
      .W (3)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({alt_clk_pin, hw_trigger, ana_cmp_above}),
      .q       (sync_q)
   );

   assign cmp_q  = sync_q[0];
   assign trig_q = sync_q[1];
   assign alt_q  = sync_q[2];

   adcc_tick u_tick (
      .aclk                (aclk),
      .aresetn             (aresetn),
      .input_clock_select  (st_r.cfg[CFG_ICLK_LSB +: 2]),
      .clock_divide_select (st_r.cfg[CFG_DIV_LSB +: 2]),
      .alt_clk             (alt_q),
      .tick                (tick)
   );

   always_comb
   begin
      st_nxt   = st_r;
      sc1_wr   = 1'b0;
      set_flag = 1'b0;

      mode8      = (st_r.cfg[CFG_MODE_LSB +: 2] == MODE_8BIT);
      stop_pos   = mode8 ? STOP_8BIT : STOP_10BIT;
      samp_ticks = st_r.cfg[CFG_LSMP_BIT] ? SAMPLE_LONG_TICKS : SAMPLE_SHORT_TICKS;
      // narrow mode keeps the top bits, so a saturated comparator gives 0xFF
      res_new    = mode8 ? {2'b00, st_r.code[9:2]} : st_r.code;
      cv_full    = {st_r.cv_hi, st_r.cv_lo};
      cmp_ok     = st_r.cfgt ? ({6'h00, res_new} >= cv_full)
                             : ({6'h00, res_new} <  cv_full);

      // write address and data are taken independently
      if (s_axi_awvalid && !st_r.aw_have)
      begin
         st_nxt.aw_have = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.w_have)
      begin
         st_nxt.w_have = 1'b1;
         st_nxt.w_data = s_axi_wdata[7:0];
         st_nxt.w_lane = s_axi_wstrb[0];
      end
      if (st_r.bvalid && s_axi_bready)
      begin
         st_nxt.bvalid = 1'b0;
      end

      if (st_r.aw_have && st_r.w_have && !st_r.bvalid)
      begin
         st_nxt.aw_have = 1'b0;
         st_nxt.w_have  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = RESP_OKAY;
         case (word_off(st_r.aw_addr))
            OFF_SC1:
            begin
               st_nxt.complete_irq_enable = st_r.w_lane ? st_r.w_data[SC1_COMPLETE_IRQ_ENABLE_BIT] : st_r.complete_irq_enable;
               st_nxt.cont = st_r.w_lane ? st_r.w_data[SC1_CONT_BIT] : st_r.cont;
               st_nxt.ch   = st_r.w_lane ? st_r.w_data[SC1_CH_LSB +: 5] : st_r.ch;
               sc1_wr      = st_r.w_lane;
            end
            OFF_SC2:
            begin
               // active flag and low nibble are not storable
               st_nxt.trg  = st_r.w_lane ? st_r.w_data[SC2_TRG_BIT] : st_r.trg;
               st_nxt.cfe  = st_r.w_lane ? st_r.w_data[SC2_CFE_BIT] : st_r.cfe;
               st_nxt.cfgt = st_r.w_lane ? st_r.w_data[SC2_CFGT_BIT] : st_r.cfgt;
            end
            OFF_RES_HI, OFF_RES_LO:
            begin
               st_nxt.bresp = RESP_OKAY;
            end
            OFF_CV_HI: st_nxt.cv_hi = byte_wr(st_r.cv_hi, st_r.w_data, st_r.w_lane);
            OFF_CV_LO: st_nxt.cv_lo = byte_wr(st_r.cv_lo, st_r.w_data, st_r.w_lane);
            OFF_CFG:   st_nxt.cfg   = byte_wr(st_r.cfg, st_r.w_data, st_r.w_lane);
            OFF_PIN1:  st_nxt.pin1  = byte_wr(st_r.pin1, st_r.w_data, st_r.w_lane);
            OFF_PIN2:  st_nxt.pin2  = byte_wr(st_r.pin2, st_r.w_data, st_r.w_lane);
            default:   st_nxt.bresp = RESP_SLVERR;
         endcase
      end

      if (st_r.rvalid && s_axi_rready)
      begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !st_r.rvalid)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = RESP_OKAY;
         st_nxt.rdata  = '0;
         case (word_off(s_axi_araddr))
            OFF_SC1:
            begin
               st_nxt.rdata[7:0] = {st_r.conversion_complete_flag, st_r.complete_irq_enable, st_r.cont, st_r.ch};
            end
            OFF_SC2:
            begin
               st_nxt.rdata[7:0] = {st_r.state != ST_IDLE, st_r.trg, st_r.cfe,
                                    st_r.cfgt, 4'h0};
            end
            OFF_RES_HI:
            begin
               st_nxt.rdata[7:0] = {6'h00, st_r.res[9:8]};
               st_nxt.lock       = 1'b1;
               st_nxt.low_hold   = st_r.res[7:0];
            end
            OFF_RES_LO:
            begin
               st_nxt.rdata[7:0] = st_r.lock ? st_r.low_hold : st_r.res[7:0];
               st_nxt.lock       = 1'b0;
            end
            OFF_CV_HI: st_nxt.rdata[7:0] = st_r.cv_hi;
            OFF_CV_LO: st_nxt.rdata[7:0] = st_r.cv_lo;
            OFF_CFG:   st_nxt.rdata[7:0] = st_r.cfg;
            OFF_PIN1:  st_nxt.rdata[7:0] = st_r.pin1;
            OFF_PIN2:  st_nxt.rdata[7:0] = st_r.pin2;
            default:   st_nxt.rresp      = RESP_SLVERR;
         endcase
      end

      st_nxt.trig_prev = trig_q;
      hw_start = st_r.trg && trig_q && !st_r.trig_prev && (st_r.state == ST_IDLE);

      case (st_r.state)
         ST_IDLE:
         begin
            st_nxt.cnt = 5'd0;
         end
         ST_SAMPLE:
         begin
            if (tick)
            begin
               if (st_r.cnt >= 5'(samp_ticks - 5'd1))
               begin
                  st_nxt.state  = ST_CONVERT;
                  st_nxt.cnt    = 5'd0;
                  st_nxt.code   = 10'h200;
                  st_nxt.pos    = CODE_MSB;
                  st_nxt.settle = 3'd0;
               end
               else
               begin
                  st_nxt.cnt = 5'(st_r.cnt + 5'd1);
               end
            end
         end
         ST_CONVERT:
         begin
            // comparator passes a synchroniser, so each trial needs bus clocks too
            if (st_r.settle != SETTLE_CLKS)
            begin
               st_nxt.settle = 3'(st_r.settle + 3'd1);
            end
            else if (tick)
            begin
               st_nxt.code[st_r.pos] = cmp_q;
               if (st_r.pos <= stop_pos)
               begin
                  st_nxt.state = ST_FINISH;
               end
               else
               begin
                  st_nxt.pos                = 4'(st_r.pos - 4'd1);
                  st_nxt.code[st_r.pos - 1] = 1'b1;
                  st_nxt.settle             = 3'd0;
               end
            end
         end
         ST_FINISH:
         begin
            // a half-read result pair holds the new one back
            if (!st_r.lock)
            begin
               if (!st_r.cfe || cmp_ok)
               begin
                  st_nxt.res = res_new;
                  set_flag   = 1'b1;
               end
               st_nxt.state = st_r.cont ? ST_SAMPLE : ST_IDLE;
               st_nxt.cnt   = 5'd0;
            end
         end
         default:
         begin
            st_nxt.state = ST_IDLE;
         end
      endcase

      if (sc1_wr)
      begin
         // write aborts whatever runs; hardware trigger waits for its edge
         st_nxt.conversion_complete_flag  = 1'b0;
         st_nxt.state = st_r.trg ? ST_IDLE : ST_SAMPLE;
         st_nxt.cnt   = 5'd0;
      end
      else if (hw_start)
      begin
         st_nxt.state = ST_SAMPLE;
         st_nxt.cnt   = 5'd0;
      end
      if (set_flag)
      begin
         st_nxt.conversion_complete_flag = 1'b1;
      end

      st_nxt.irq           = st_nxt.conversion_complete_flag && st_nxt.complete_irq_enable;
      st_nxt.ana.sample    = (st_nxt.state == ST_SAMPLE);
      st_nxt.ana.channel   = st_nxt.ch;
      st_nxt.ana.code      = st_nxt.code;
      st_nxt.ana.low_power = st_nxt.cfg[CFG_LP_BIT];
      st_nxt.ana.active    = (st_nxt.state != ST_IDLE);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r       <= '0;
         st_r.cfg   <= CFG_RST;
         st_r.ch    <= SC1_RST[4:0];
         st_r.cv_hi <= BYTE_RST;
         st_r.cv_lo <= BYTE_RST;
         st_r.pin1  <= BYTE_RST;
         st_r.pin2  <= BYTE_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready       = !st_r.aw_have;
   assign s_axi_wready        = !st_r.w_have;
   assign s_axi_bvalid        = st_r.bvalid;
   assign s_axi_bresp         = st_r.bresp;
   assign s_axi_arready       = !st_r.rvalid;
   assign s_axi_rvalid        = st_r.rvalid;
   assign s_axi_rdata         = st_r.rdata;
   assign s_axi_rresp         = st_r.rresp;
   assign ana_o               = st_r.ana;
   assign pin_digital_disable = {st_r.pin2, st_r.pin1};
   assign complete_irq        = st_r.irq;
endmodule
`default_nettype wire

/* tb/adcc_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_asserts (
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic [5:0]          s_axi_awaddr,
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic [31:0]         s_axi_wdata,
   input wire logic [3:0]          s_axi_wstrb,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic [1:0]          s_axi_bresp,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   input wire adcc_pkg::adcc_ana_t ana_o,
   input wire logic [15:0]         pin_digital_disable,
   input wire logic                complete_irq
);
   import adcc_pkg::*;
   logic wr_take;
   // address and data taken on the same edge, as the bench always offers them
   assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                    && s_axi_wstrb[0];
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000) else $error("read answer wrong");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_low_power_follows: assert property (wr_take && s_axi_awaddr == OFF_CFG |->
      ##2 ana_o.low_power == $past(s_axi_wdata[7], 2)) else $error("low power wrong");
   a_pin_follows: assert property (wr_take && s_axi_awaddr == OFF_PIN1 |->
      ##2 pin_digital_disable[7:0] == $past(s_axi_wdata[7:0], 2))
      else $error("pin control wrong");
   a_irq_clears: assert property (wr_take && s_axi_awaddr == OFF_SC1 |->
      ##3 !complete_irq) else $error("flag not cleared");
   a_sample_min: assert property ($fell(ana_o.sample) && ana_o.active |->
      $past(ana_o.sample, 4)) else $error("sample too short");
   a_sample_active: assert property (ana_o.sample |-> ana_o.active)
      else $error("sample while idle");
endmodule
bind adcc_ctrl adcc_ctrl_asserts u_chk (.*);
`default_nettype wire

/* tb/adcc_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
   input  wire logic                aclk,
   input  wire adcc_pkg::adcc_ana_t ana,
   input  wire logic [9:0]          level,
   output logic                     cmp_above
);
   import adcc_pkg::*;
   logic toggle_r = 1'b0;
   // an idle core gives no usable answer, so the line keeps changing
   always_ff @(posedge aclk)
      toggle_r <= ~toggle_r;
   assign cmp_above = ana.active ? (level >= ana.code) : toggle_r;
endmodule
`default_nettype wire

/* tb/adcc_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_bench;
   import adcc_pkg::*;
   typedef struct packed
   {
      logic [7:0] cfg;
      logic [9:0] level;
      logic [7:0] hi;
      logic [7:0] lo;
      logic [7:0] samp;
   } adcc_row_t;
   localparam int LIMIT = 40000;
   // samp 0: divided tick phase makes the exact length uncertain
   adcc_row_t rows [8] = '{
      '{8'h98, 10'h2A5, 8'h02, 8'hA5, 8'h18},
      '{8'h00, 10'h3FF, 8'h00, 8'hFF, 8'h04},
      '{8'h08, 10'h000, 8'h00, 8'h00, 8'h04},
      '{8'h28, 10'h3FF, 8'h03, 8'hFF, 8'h00},
      '{8'h19, 10'h155, 8'h01, 8'h55, 8'h00},
      '{8'h0C, 10'h2A5, 8'h02, 8'hA5, 8'h04},
      '{8'h60, 10'h2A5, 8'h00, 8'hA9, 8'h00},
      '{8'h4A, 10'h2A5, 8'h02, 8'hA5, 8'h00}};
   logic        aclk = 1'b0, aresetn = 1'b0, alt_clk_pin = 1'b0, hw_trigger = 1'b0;
   logic [5:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        ana_cmp_above, complete_irq;
   logic [15:0] pin_digital_disable;
   adcc_ana_t   ana_o;
   logic [9:0]  level = '0;
   logic [7:0]  run = '0, samp_len = '0;
   int          n_errors = 0, total_checks = 0, cycles = 0;

   adcc_ctrl DUT (.*);
   adcc_analog_model u_ana (.aclk(aclk), .ana(ana_o), .level(level), .cmp_above(ana_cmp_above));

   always #25 aclk = ~aclk;

   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      // free-running alternate clock, six bus clocks a period
      if (cycles % 3 == 0)
         alt_clk_pin <= ~alt_clk_pin;
      if (ana_o.sample === 1'b1)
         run <= run + 8'h01;
      else if (run != 8'h00)
      begin
         samp_len <= run;
         run <= 8'h00;
      end
      if (cycles == LIMIT)
      begin
         n_errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // decide at the falling edge what the next rising edge takes
   task automatic xfer(input bit we, input logic [5:0] a, input logic [7:0] d,
                       output logic [31:0] qd, output logic [1:0] rs);
      logic ta, tw, tr, done;
      @(posedge aclk);
      if (we)
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'h000000, d};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end
      else
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      done = 1'b0;
      while (!done)
      begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tr = s_axi_arvalid & s_axi_arready;
         done = we ? s_axi_bvalid : s_axi_rvalid;
         qd = s_axi_rdata;
         rs = we ? s_axi_bresp : s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
         if (done) {s_axi_bready, s_axi_rready} <= 2'b00;
      end
   endtask

   task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 8'h00, q, r);
      chk(what, exp, q);
   endtask

   task automatic wait_done();
      for (int k = 0; k < 2000 && complete_irq !== 1'b1; k++)
         @(negedge aclk);
      chk("irq", 32'h1, 32'(complete_irq));
   endtask

   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 9; a++)
         rd_chk("reset", 6'(a * 4), 32'h0);
      xfer(1'b1, OFF_SC2, 8'h3C, q, r);
      rd_chk("sc2", OFF_SC2, 32'h30);
      xfer(1'b1, OFF_PIN1, 8'h02, q, r);
      chk("pins", 32'h2, 32'(pin_digital_disable));
      xfer(1'b1, 6'h24, 8'h55, q, r);
      chk("bresp", 32'(RESP_SLVERR), 32'(r));
      rd_chk("unmapped", 6'h24, 32'h0);
      chk("rresp", 32'(RESP_SLVERR), 32'(r));
      foreach (rows[i])
      begin
         xfer(1'b1, OFF_CFG, rows[i].cfg, q, r);
         xfer(1'b1, OFF_SC2, 8'h00, q, r);
         level <= rows[i].level;
         xfer(1'b1, OFF_SC1, 8'h41, q, r);
         wait_done();
         chk("channel", 32'h1, 32'(ana_o.channel));
         rd_chk("flag", OFF_SC1, 32'hC1);
         rd_chk("res hi", OFF_RES_HI, 32'(rows[i].hi));
         rd_chk("res lo", OFF_RES_LO, 32'(rows[i].lo));
         if (rows[i].samp != 8'h00)
            chk("sample", 32'(rows[i].samp), 32'(samp_len));
      end
      xfer(1'b1, OFF_CFG, 8'h08, q, r);
      xfer(1'b1, OFF_CV_HI, 8'h03, q, r);
      xfer(1'b1, OFF_CV_LO, 8'h00, q, r);
      xfer(1'b1, OFF_SC2, 8'h30, q, r);
      xfer(1'b1, OFF_SC1, 8'h41, q, r);
      repeat (300) @(posedge aclk);
      rd_chk("cmp gt", OFF_SC1, 32'h41);
      xfer(1'b1, OFF_SC2, 8'h20, q, r);
      xfer(1'b1, OFF_SC1, 8'h41, q, r);
      wait_done();
      rd_chk("cmp lt", OFF_RES_LO, 32'hA5);
      s_axi_wstrb <= 4'h0;
      xfer(1'b1, OFF_CV_HI, 8'hFF, q, r);
      rd_chk("no lane", OFF_CV_HI, 32'h03);
      s_axi_wstrb <= 4'h1;
      xfer(1'b1, OFF_SC2, 8'h40, q, r);
      xfer(1'b1, OFF_SC1, 8'h41, q, r);
      repeat (20) @(posedge aclk);
      chk("wait trig", 32'h0, 32'(ana_o.active));
      hw_trigger <= 1'b1;
      repeat (6) @(posedge aclk);
      hw_trigger <= 1'b0;
      wait_done();
      rd_chk("trig", OFF_SC2, 32'h40);
      xfer(1'b1, OFF_SC2, 8'h00, q, r);
      xfer(1'b1, OFF_SC1, 8'h61, q, r);
      wait_done();
      rd_chk("active", OFF_SC2, 32'h80);
      level <= 10'h155;
      rd_chk("cont hi", OFF_RES_HI, 32'h02);
      rd_chk("cont lo", OFF_RES_LO, 32'hA5);
      repeat (300) @(posedge aclk);
      rd_chk("next hi", OFF_RES_HI, 32'h01);
      rd_chk("next lo", OFF_RES_LO, 32'h55);
      xfer(1'b1, OFF_SC1, 8'h01, q, r);
      repeat (300) @(posedge aclk);
      chk("irq off", 32'h0, 32'(complete_irq));
      rd_chk("done", OFF_SC1, 32'h81);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk("cfg rst", OFF_CFG, 32'h0);
      stop_test();
   end
endmodule
`default_nettype wire
